// ### core/ppc_diag_seq.sv
// ppc_diag_seq: cable diagnostic sequencer. starts the analog tester,
// waits for its done flag or a timeout, and latches the outcome.
// assumes tester done is a one-cycle pulse synchronous to the clock.
`timescale 1ns/100ps
module ppc_diag_seq #(
    parameter int TIMEOUT = ppc_pkg::TEST_CYC * 64
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             start_i,     // software wrote the enable bit
    input  wire logic             done_i,      // tester finished
    input  wire ppc_pkg::ppc_diag_t res_i,     // tester outcome
    output logic                  busy_o,      // enable bit readback
    output logic                  go_o,        // tester kick, one cycle
    output logic                  fin_o,       // finish pulse
    output ppc_pkg::ppc_diag_t    res_o        // held outcome
);
    typedef enum logic [1:0] {IDLE, KICK, WAIT} ppc_dst_t;

    ppc_dst_t          st_q;                   // sequencer state
    ppc_dst_t          st_d;
    logic [31:0]       tmo_q;                  // timeout counter
    wire               tmo_hit = (tmo_q == 32'(TIMEOUT));

    // next state
    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            IDLE: if (start_i) st_d = KICK;
            KICK: st_d = WAIT;
            WAIT: if (done_i || tmo_hit) st_d = IDLE;
        endcase
    end

    assign busy_o = (st_q != IDLE);
    assign go_o   = (st_q == KICK);
    assign fin_o  = (st_q == WAIT) && (done_i || tmo_hit);

    // state, timeout and result registers
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q  <= IDLE;
            tmo_q <= '0;
            res_o <= '0;
        end
        else
        begin
            st_q  <= st_d;
            tmo_q <= (st_q == WAIT) ? tmo_q + 32'd1 : 32'd0;
            // a tester that never answers reports failure
            if (st_q == WAIT && done_i)
                res_o <= res_i;
            else if (st_q == WAIT && tmo_hit)
                res_o <= '{res: ppc_pkg::RES_FAIL, cnt: '0};
        end
    end
endmodule : ppc_diag_seq

// ### core/ppc_irq.sv
// ppc_irq: sticky event status with read-to-clear and a mask.
// assumes events and read strobe are synchronous one-cycle pulses.
`timescale 1ns/100ps
module ppc_irq #(
    parameter int W = ppc_pkg::IRQ_W
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] evt_i,       // event pulses
    input  wire logic         rd_clr_i,    // status register read
    input  wire logic [W-1:0] mask_i,      // one enables a source
    output logic [W-1:0]      stat_o,      // sticky status
    output logic              irq_o        // level interrupt
);
    // a new event in the clearing read's cycle survives: set wins
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            stat_o <= '0;
            irq_o  <= 1'b0;
        end
        else
        begin
            stat_o <= (rd_clr_i ? '0 : stat_o) | evt_i;
            irq_o  <= |(((rd_clr_i ? '0 : stat_o) | evt_i) & mask_i);
        end
    end
endmodule : ppc_irq

// ### core/ppc_top.sv
// ppc_top: port phy control and cable diagnostic register pair with the
// mirrored mii control and advert views, led gating and phy controls.
// assumes a simple strobe register port, read data one cycle after strobe.
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
module ppc_top #(
    parameter int TIMEOUT = ppc_pkg::TEST_CYC * 64   // tester watchdog
) (
    input  wire logic         MCLK_I,
    input  wire logic         RSTN_I,
    // register port
    input  wire logic [7:0]   ADDR_I,
    input  wire logic [15:0]  WDATA_I,
    input  wire logic         WR_I,
    input  wire logic         RD_I,
    output logic [15:0]       RDATA_O,
    output logic              IRQ_O,
    // phy core status
    input  wire logic         LINK_RAW_I,      // link from the phy receiver
    input  wire logic         ANEG_FAIL_I,     // negotiation gave up
    input  wire logic [3:0]   LED_RAW_I,       // normal led drive, 0 = lit
    // analog cable tester
    input  wire logic         DIAG_DONE_I,
    input  wire logic [1:0]   DIAG_RES_I,
    input  wire logic [8:0]   DIAG_CNT_I,
    output logic              DIAG_GO_O,
    // phy controls
    output logic              LINK_OK_O,
    output logic              REMOTE_LB_O,
    output logic              TX_DISABLE_O,
    output logic              ANEG_RESTART_O,  // one-cycle pulse
    output logic              ANEG_EN_O,
    output logic              SPEED_100_O,
    output logic              FULL_DPX_O,
    output logic              AUTO_X_EN_O,
    output logic              MDIX_FORCE_O,
    output logic [4:0]        ADVERT_O,
    output logic              PORT_LED_OUT_3_O,
    output logic              PORT_LED_OUT_2_O,
    output logic              PORT_LED_OUT_1_O,
    output logic              PORT_LED_OUT_0_O
);
    // reset release through two flops
    logic              rst_m_q;
    logic              rst_n;
    always_ff @(posedge MCLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            rst_m_q <= 1'b0;
            rst_n   <= 1'b0;
        end
        else
        begin
            rst_m_q <= 1'b1;
            rst_n   <= rst_m_q;
        end
    end

    // single control store, the special, port, mii and advert views all decode into it
    ppc_pkg::ppc_ctrl_t ctrl_q;
    ppc_pkg::ppc_ctrl_t ctrl_d;

    // address decode
    wire wr_sc   = WR_I && (ADDR_I == ppc_pkg::OFS_SCLMD);
    wire wr_pc   = WR_I && (ADDR_I == ppc_pkg::OFS_PCR);
    wire wr_mb   = WR_I && (ADDR_I == ppc_pkg::OFS_MBCR);
    wire wr_an   = WR_I && (ADDR_I == ppc_pkg::OFS_ANAR);
    wire wr_im   = WR_I && (ADDR_I == ppc_pkg::OFS_IMR);
    wire rd_is   = RD_I && (ADDR_I == ppc_pkg::OFS_ISR);

    // test start: writing one while idle; a write during a test is ignored
    wire diag_start = wr_sc && WDATA_I[ppc_pkg::SC_EN];
    // restart through either view
    wire restart    = (wr_pc && WDATA_I[ppc_pkg::PC_RSTAN])
                   || (wr_mb && WDATA_I[ppc_pkg::MB_RSTAN]);

    // cable diagnostic sequencer
    logic               diag_busy;
    logic               diag_go;
    logic               diag_fin;
    ppc_pkg::ppc_diag_t diag_res;
    ppc_pkg::ppc_diag_t diag_in;               // tester outcome as one word
    assign diag_in = '{res: DIAG_RES_I, cnt: DIAG_CNT_I};
    ppc_diag_seq #(
        .TIMEOUT (TIMEOUT)
    ) u_diag (
        .clk_i   (MCLK_I),
        .rst_n_i (rst_n),
        .start_i (diag_start),
        .done_i  (DIAG_DONE_I),
        .res_i   (diag_in),
        .busy_o  (diag_busy),
        .go_o    (diag_go),
        .fin_o   (diag_fin),
        .res_o   (diag_res)
    );

    // effective link and its change event
    wire  link_eff = LINK_RAW_I || ctrl_q.force_link;
    logic link_q;

    // interrupt block: test done and link change
    logic [ppc_pkg::IRQ_W-1:0] irq_mask_q;
    logic [ppc_pkg::IRQ_W-1:0] irq_stat;
    logic                      irq;
    wire  [ppc_pkg::IRQ_W-1:0] irq_evt = {link_eff ^ link_q, diag_fin};
    ppc_irq #(
        .W (ppc_pkg::IRQ_W)
    ) u_irq (
        .clk_i    (MCLK_I),
        .rst_n_i  (rst_n),
        .evt_i    (irq_evt),
        .rd_clr_i (rd_is),
        .mask_i   (irq_mask_q),
        .stat_o   (irq_stat),
        .irq_o    (irq)
    );

    // next control value: the later view in a cycle never collides,
    // because one strobe carries one address
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_sc)
        begin
            ctrl_d.force_link = WDATA_I[ppc_pkg::SC_FLNK];
            ctrl_d.remote_lb  = WDATA_I[ppc_pkg::SC_RLB];
        end
        if (wr_pc)
        begin
            ctrl_d.led_off    = WDATA_I[ppc_pkg::PC_LEDOFF];
            ctrl_d.tx_disable = WDATA_I[ppc_pkg::PC_TXDIS];
            ctrl_d.auto_x_dis = WDATA_I[ppc_pkg::PC_XDIS];
            ctrl_d.force_mdix = WDATA_I[ppc_pkg::PC_FMDIX];
            ctrl_d.aneg_en    = WDATA_I[ppc_pkg::PC_ANEN];
            ctrl_d.force_spd  = WDATA_I[ppc_pkg::PC_SPD];
            ctrl_d.force_dpx  = WDATA_I[ppc_pkg::PC_DPX];
            ctrl_d.advert     = WDATA_I[4:0];
        end
        if (wr_mb)
        begin
            // same storage reached from the mii basic control view
            ctrl_d.led_off    = WDATA_I[ppc_pkg::MB_LEDOFF];
            ctrl_d.tx_disable = WDATA_I[ppc_pkg::MB_TXDIS];
            ctrl_d.auto_x_dis = WDATA_I[ppc_pkg::MB_XDIS];
            ctrl_d.force_mdix = WDATA_I[ppc_pkg::MB_FMDIX];
            ctrl_d.aneg_en    = WDATA_I[ppc_pkg::MB_ANEN];
            ctrl_d.force_spd  = WDATA_I[ppc_pkg::MB_SPD];
            ctrl_d.force_dpx  = WDATA_I[ppc_pkg::MB_DPX];
        end
        if (wr_an)
        begin
            // advert view: pause at 10, modes at 8..5
            ctrl_d.advert = {WDATA_I[ppc_pkg::AN_PAUSE],
                             WDATA_I[ppc_pkg::AN_MODE_LO+3:ppc_pkg::AN_MODE_LO]};
        end
    end

    // read data for each view
    wire [15:0] rd_sc = {1'b0, diag_res.res, diag_busy, ctrl_q.force_link,
                         1'b0, ctrl_q.remote_lb, diag_res.cnt};
    wire [15:0] rd_pc = {ctrl_q.led_off, ctrl_q.tx_disable, 1'b0, 2'b00,
                         ctrl_q.auto_x_dis, ctrl_q.force_mdix, 1'b0,
                         ctrl_q.aneg_en, ctrl_q.force_spd, ctrl_q.force_dpx,
                         ctrl_q.advert};
    // restart at bit 9 is a strobe and reads zero
    wire [15:0] rd_mb = {2'b00, ctrl_q.force_spd, ctrl_q.aneg_en, 3'b000,
                         ctrl_q.force_dpx, 3'b000, ctrl_q.force_mdix,
                         ctrl_q.auto_x_dis, 1'b0, ctrl_q.tx_disable,
                         ctrl_q.led_off};
    wire [15:0] rd_an = {5'h00, ctrl_q.advert[4], 1'b0, ctrl_q.advert[3:0],
                         ppc_pkg::AN_SELECTOR};
    wire [15:0] rd_mux =
        (ADDR_I == ppc_pkg::OFS_SCLMD) ? rd_sc :
        (ADDR_I == ppc_pkg::OFS_PCR)   ? rd_pc :
        (ADDR_I == ppc_pkg::OFS_MBCR)  ? rd_mb :
        (ADDR_I == ppc_pkg::OFS_ANAR)  ? rd_an :
        (ADDR_I == ppc_pkg::OFS_ISR)   ? {14'h0000, irq_stat} :
        (ADDR_I == ppc_pkg::OFS_IMR)   ? {14'h0000, irq_mask_q} :
                                         16'h0000;       // unmapped reads zero

    // derived phy drives
    wire        dpx_eff  = ctrl_q.aneg_en ? !ANEG_FAIL_I || ctrl_q.force_dpx
                                          : ctrl_q.force_dpx;
    wire [3:0]  led_eff  = ctrl_q.led_off ? 4'hf : LED_RAW_I;

    // register bank and flopped outputs
    always_ff @(posedge MCLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q     <= '{advert: ppc_pkg::ADV_RST, aneg_en: ppc_pkg::ANEN_RST,
                            force_spd: ppc_pkg::SPD_RST,
                            force_dpx: ppc_pkg::DPX_RST, default: 1'b0};
            irq_mask_q <= '0;
            link_q     <= 1'b0;
            RDATA_O    <= 16'h0000;
        end
        else
        begin
            ctrl_q     <= ctrl_d;
            link_q     <= link_eff;
            if (wr_im)
                irq_mask_q <= WDATA_I[ppc_pkg::IRQ_W-1:0];
            RDATA_O    <= RD_I ? rd_mux : 16'h0000;
        end
    end

    // interrupt, tester kick and phy control outputs, each from a flop
    always_ff @(posedge MCLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            IRQ_O            <= 1'b0;
            DIAG_GO_O        <= 1'b0;
            LINK_OK_O        <= 1'b0;
            REMOTE_LB_O      <= 1'b0;
            TX_DISABLE_O     <= 1'b0;
            ANEG_RESTART_O   <= 1'b0;
            ANEG_EN_O        <= 1'b0;
            SPEED_100_O      <= 1'b0;
            FULL_DPX_O       <= 1'b0;
            AUTO_X_EN_O      <= 1'b0;
            MDIX_FORCE_O     <= 1'b0;
            ADVERT_O         <= 5'h00;
            {PORT_LED_OUT_3_O, PORT_LED_OUT_2_O,
             PORT_LED_OUT_1_O, PORT_LED_OUT_0_O} <= 4'hf;
        end
        else
        begin
            IRQ_O            <= irq;
            DIAG_GO_O        <= diag_go;
            LINK_OK_O        <= link_eff;
            REMOTE_LB_O      <= ctrl_q.remote_lb;
            TX_DISABLE_O     <= ctrl_q.tx_disable;
            ANEG_RESTART_O   <= restart;
            ANEG_EN_O        <= ctrl_q.aneg_en;
            SPEED_100_O      <= ctrl_q.force_spd;
            FULL_DPX_O       <= dpx_eff;
            AUTO_X_EN_O      <= !ctrl_q.auto_x_dis;
            MDIX_FORCE_O     <= ctrl_q.auto_x_dis && ctrl_q.force_mdix;
            ADVERT_O         <= ctrl_q.advert;
            {PORT_LED_OUT_3_O, PORT_LED_OUT_2_O,
             PORT_LED_OUT_1_O, PORT_LED_OUT_0_O} <= led_eff;
        end
    end
endmodule : ppc_top

// ### shared/ppc_pkg.sv
// ppc_pkg: register map, field positions, reset values and types for the
// port phy control and cable diagnostic register pair.
// assumes a 16-bit register port with byte offsets as the addresses.
// Functional notes
// - cable result: 00 ok, 01 open, 10 short, 11 fail
// - test enable bit starts test, self-clears
// - nine-bit fault count, about 0.4 m each
// - force link makes link report pass
// - remote loopback: receive pair onto transmit pair
// - led off drives all four leds high
// - transmit disable turns transmitter off
// - restart bit starts new auto-negotiation
// - crossover disable stops automatic mdi/mdi-x
// - force mdi-x only while auto crossover disabled
// - aneg enable, else forced speed and duplex
// - forced speed: one 100, zero 10
// - force duplex also when negotiation fails
// - five bits advertise pause and four modes
package ppc_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_MBCR   = 8'he4;   // mii basic control view
    localparam logic [7:0] OFS_ANAR   = 8'hec;   // autoneg advert view
    localparam logic [7:0] OFS_SCLMD  = 8'hf4;   // special ctrl / cable diag
    localparam logic [7:0] OFS_PCR    = 8'hf6;   // port phy control
    localparam logic [7:0] OFS_ISR    = 8'hfa;   // interrupt status
    localparam logic [7:0] OFS_IMR    = 8'hfc;   // interrupt mask

    // special ctrl / cable diag fields
    localparam int SC_RES_HI   = 14;
    localparam int SC_RES_LO   = 13;
    localparam int SC_EN       = 12;
    localparam int SC_FLNK     = 11;
    localparam int SC_RLB      = 9;
    localparam int SC_CNT_HI   = 8;

    // port phy control fields
    localparam int PC_LEDOFF   = 15;
    localparam int PC_TXDIS    = 14;
    localparam int PC_RSTAN    = 13;
    localparam int PC_XDIS     = 10;
    localparam int PC_FMDIX    = 9;
    localparam int PC_ANEN     = 7;
    localparam int PC_SPD      = 6;
    localparam int PC_DPX      = 5;

    // mirrored positions in the mii basic control view
    localparam int MB_SPD      = 13;
    localparam int MB_ANEN     = 12;
    localparam int MB_RSTAN    = 9;
    localparam int MB_DPX      = 8;
    localparam int MB_FMDIX    = 4;
    localparam int MB_XDIS     = 3;
    localparam int MB_TXDIS    = 1;
    localparam int MB_LEDOFF   = 0;

    // advert view: bit 10 pause, bits 8..5 the four modes, selector 4..0
    localparam int AN_PAUSE    = 10;
    localparam int AN_MODE_LO  = 5;
    localparam logic [4:0] AN_SELECTOR = 5'h01;

    // reset values
    localparam logic [4:0] ADV_RST     = 5'h1f;  // all five advertised
    localparam logic       ANEN_RST    = 1'b1;
    localparam logic       SPD_RST     = 1'b1;
    localparam logic       DPX_RST     = 1'b1;

    // cable diagnostic
    localparam int CNT_W       = 9;
    localparam int RES_W       = 2;
    localparam int TEST_NS     = 1000;           // default test length
    localparam int CLK_NS      = 8;
    localparam int TEST_CYC    = (TEST_NS + CLK_NS - 1) / CLK_NS;

    // interrupt status bits
    localparam int IRQ_DONE    = 0;              // cable test done
    localparam int IRQ_LINK    = 1;              // link status change
    localparam int IRQ_W       = 2;

    // cable result codes
    typedef enum logic [1:0] {
        RES_NORMAL = 2'h0,
        RES_OPEN   = 2'h1,
        RES_SHORT  = 2'h2,
        RES_FAIL   = 2'h3
    } ppc_res_t;

    // control bits presented to the phy core
    typedef struct packed {
        logic       led_off;
        logic       tx_disable;
        logic       force_link;
        logic       remote_lb;
        logic       auto_x_dis;
        logic       force_mdix;
        logic       aneg_en;
        logic       force_spd;
        logic       force_dpx;
        logic [4:0] advert;      // pause, 100f, 100h, 10f, 10h
    } ppc_ctrl_t;

    // outcome delivered by the analog cable tester
    typedef struct packed {
        logic [1:0]       res;
        logic [CNT_W-1:0] cnt;
    } ppc_diag_t;

endpackage : ppc_pkg

// ### tb/ppc_top_bench.sv
// ppc_top_bench: self-checking bench for the port phy control register pair.
// assumes the design answers reads one cycle after the strobe, never stalls.
`timescale 1ns/100ps
module ppc_top_bench;
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd_s = 1'b0, rd_d = 1'b0;
    logic raw_lnk = 1'b0, fail = 1'b0, done = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdat = 16'h0000, rdata, p, last = 16'h0000;
    logic [3:0] raw_led = 4'h0, led, adv4;
    logic [1:0] dres = 2'h0;
    logic [8:0] dcnt = 9'h000, c;
    logic irq, go, lok, rlb, txd, rsa, anen, spd, fdx, axen, mdix;
    logic [4:0] adv;
    logic [15:0] expq[$];   // expected read data, oldest first
    int err_count = 0, n_tests = 0, cyc = 0, i, j;

    ppc_top #(.TIMEOUT(20)) i_dut (.MCLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr),
        .WDATA_I(wdat), .WR_I(wr), .RD_I(rd_s), .RDATA_O(rdata), .IRQ_O(irq),
        .LINK_RAW_I(raw_lnk), .ANEG_FAIL_I(fail), .LED_RAW_I(raw_led),
        .DIAG_DONE_I(done), .DIAG_RES_I(dres), .DIAG_CNT_I(dcnt), .DIAG_GO_O(go),
        .LINK_OK_O(lok), .REMOTE_LB_O(rlb), .TX_DISABLE_O(txd), .ANEG_RESTART_O(rsa),
        .ANEG_EN_O(anen), .SPEED_100_O(spd), .FULL_DPX_O(fdx), .AUTO_X_EN_O(axen),
        .MDIX_FORCE_O(mdix), .ADVERT_O(adv), .PORT_LED_OUT_3_O(led[3]),
        .PORT_LED_OUT_2_O(led[2]), .PORT_LED_OUT_1_O(led[1]), .PORT_LED_OUT_0_O(led[0]));

    // 125 MHz clock
    initial
    begin
        forever #4 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    // one-cycle strobes with a quiet cycle after, so no signal is set twice per step
    task automatic wrr(input logic [7:0] a, input logic [15:0] d);
        addr <= a; wdat <= d; wr <= 1'b1;
        @(posedge clk) wr <= 1'b0;
        @(posedge clk);
    endtask : wrr

    task automatic rdr(input logic [7:0] a, input logic [15:0] e);
        expq.push_back(e);
        addr <= a; rd_s <= 1'b1;
        @(posedge clk) rd_s <= 1'b0;
        @(posedge clk);
    endtask : rdr

    // mirrored mii control and advert views of a port control word
    function automatic logic [15:0] fe4(input logic [15:0] q);
        return {2'b00, q[6], q[7], 3'b000, q[5], 3'b000, q[9], q[10], 1'b0, q[14], q[15]};
    endfunction : fe4

    function automatic logic [15:0] fec(input logic [15:0] q);
        return {5'h00, q[4], 1'b0, q[3:0], 5'h01};
    endfunction : fec

    // read data stand in the cycle after the strobe; sampled at its closing edge
    always @(posedge clk)
    begin
        rd_d <= rd_s;
        if (rd_d && expq.size() == 0) chk("spare read", 16'h0001, 16'h0000);
        else if (rd_d) chk("rdata", rdata, expq.pop_front());
    end

    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 5000)
        begin
            err_count++;
            test_done();
        end
    end

    initial
    begin
        void'($urandom(32'h9621));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        rdr(8'hf6, 16'h00ff);
        rdr(8'hf4, 16'h0000);
        rdr(8'he4, 16'h3100);
        rdr(8'hec, 16'h05e1);
        rdr(8'hfc, 16'h0000);
        rdr(8'h10, 16'h0000);
        // cable test, every result code, interrupt masked on the first
        for (i = 0; i < 4; i++)
        begin
            c = 9'($urandom());
            wrr(8'hfc, {15'h0000, i != 0});
            wrr(8'hf4, 16'h1000);
            for (j = 0; j < 8 && go !== 1'b1; j++) @(posedge clk);
            chk("go", go, 16'h0001);
            // the previous outcome stays visible until this test ends
            rdr(8'hf4, last | 16'h1000);
            done <= 1'b1; dres <= 2'(i); dcnt <= c;
            @(posedge clk) done <= 1'b0; dres <= ~2'(i); dcnt <= ~c;
            repeat (3) @(posedge clk);
            chk("irq", irq, {15'h0000, i != 0});
            last = {1'b0, 2'(i), 4'h0, c};
            rdr(8'hf4, last);
            rdr(8'hfa, 16'h0001);
            repeat (2) @(posedge clk);
            chk("irq clear", irq, 16'h0000);
        end
        // no answer from the tester: watchdog reports a failed test
        wrr(8'hf4, 16'h1000);
        repeat (30) @(posedge clk);
        rdr(8'hf4, 16'h6000);
        rdr(8'hfa, 16'h0001);
        // random control words, restart bit on odd passes
        for (i = 0; i < 8; i++)
        begin
            p = 16'($urandom()) & 16'hc6ff;
            fail <= 1'($urandom());
            raw_led <= 4'($urandom());
            wrr(8'hf6, p | {2'b00, i[0], 13'h0000});
            repeat (3) @(posedge clk);
            chk("txdis", txd, p[14]);
            chk("aneg", anen, p[7]);
            chk("speed", spd, p[6]);
            chk("duplex", fdx, (p[7] && !fail) ? 1'b1 : p[5]);
            chk("autox", axen, !p[10]);
            chk("mdix", mdix, p[9] & p[10]);
            chk("advert", adv, p[4:0]);
            adv4 = p[15] ? 4'hf : raw_led;
            chk("leds", led, adv4);
            rdr(8'hf6, p);
            rdr(8'he4, fe4(p));
            rdr(8'hec, fec(p));
        end
        // writes through the mirrored views land in the port control word
        wrr(8'he4, 16'h0201);
        chk("restart", rsa, 16'h0001);
        rdr(8'hf6, (p & 16'h001f) | 16'h8000);
        wrr(8'hec, 16'h0000);
        rdr(8'hf6, 16'h8000);
        rdr(8'hec, 16'h0001);
        // forced link and remote loopback with the line down
        wrr(8'hf4, 16'h0a00);
        repeat (3) @(posedge clk);
        chk("link", lok, 16'h0001);
        chk("loopback", rlb, 16'h0001);
        rdr(8'hf4, 16'h6a00);
        wrr(8'hf4, 16'h0000);
        repeat (3) @(posedge clk);
        chk("link", lok, 16'h0000);
        chk("loopback", rlb, 16'h0000);
        raw_lnk <= 1'b1;
        repeat (3) @(posedge clk);
        chk("link", lok, 16'h0001);
        chk("queue", 16'(expq.size()), 16'h0000);
        test_done();
    end
endmodule : ppc_top_bench

// ### tb/ppc_top_properties.sv
// ppc_top_chk: port timing checks for the port phy control register pair.
// assumes it is bound to ppc_top and sees only that module's ports.
`timescale 1ns/100ps
module ppc_top_chk (
    input wire logic        MCLK_I,
    input wire logic        RSTN_I,
    input wire logic [7:0]  ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic [15:0] RDATA_O,
    input wire logic        IRQ_O,
    input wire logic        LINK_RAW_I,
    input wire logic [3:0]  LED_RAW_I,
    input wire logic        DIAG_GO_O,
    input wire logic        LINK_OK_O,
    input wire logic        TX_DISABLE_O,
    input wire logic        ANEG_RESTART_O,
    input wire logic        AUTO_X_EN_O,
    input wire logic        MDIX_FORCE_O,
    input wire logic        PORT_LED_OUT_3_O,
    input wire logic        PORT_LED_OUT_2_O,
    input wire logic        PORT_LED_OUT_1_O,
    input wire logic        PORT_LED_OUT_0_O
);
    logic [1:0] up_q;   // edges since reset release, saturating
    wire        live = (up_q == 2'h3);   // reset synchroniser has drained
    wire [3:0]  led = {PORT_LED_OUT_3_O, PORT_LED_OUT_2_O, PORT_LED_OUT_1_O, PORT_LED_OUT_0_O};
    wire        wr_pcr = WR_I && (ADDR_I == 8'hf6);   // port control write

    // the design releases reset through two flops, so hold checks off meanwhile
    always_ff @(posedge MCLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I) up_q <= 2'h0;
        else if (!live) up_q <= up_q + 2'h1;
    end

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I || !live);

    AST_LED_OFF: assert property (wr_pcr && WDATA_I[15] |-> ##2 led == 4'hf)
        else $error("leds not dark after led off");
    AST_LED_ON: assert property (wr_pcr && !WDATA_I[15] |-> ##2 led == $past(LED_RAW_I))
        else $error("leds do not follow raw drive");
    AST_TXDIS: assert property (wr_pcr |-> ##2 TX_DISABLE_O == $past(WDATA_I[14], 2))
        else $error("transmit disable wrong");
    AST_RESTART: assert property (wr_pcr && WDATA_I[13] |-> ##[1:2] ANEG_RESTART_O)
        else $error("no negotiation restart pulse");
    AST_GO_CAUSE: assert property (DIAG_GO_O |-> $past(WR_I, 2) && $past(ADDR_I, 2) == 8'hf4
        && $past(WDATA_I[12], 2) ##1 !DIAG_GO_O)
        else $error("tester kick without enable write");
    AST_MDIX: assert property (MDIX_FORCE_O |-> !AUTO_X_EN_O)
        else $error("mdi-x forced while auto crossover on");
    AST_LINK: assert property ($past(LINK_RAW_I) |-> LINK_OK_O)
        else $error("link lost while raw link up");
    AST_RD_IDLE: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
        else $error("read data outside read slot");

    COV_GO: cover property (DIAG_GO_O);
    COV_IRQ: cover property ($rose(IRQ_O));
    COV_RST: cover property (ANEG_RESTART_O);
endmodule : ppc_top_chk

bind ppc_top ppc_top_chk i_chk (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .IRQ_O(IRQ_O),
    .LINK_RAW_I(LINK_RAW_I), .LED_RAW_I(LED_RAW_I), .DIAG_GO_O(DIAG_GO_O),
    .LINK_OK_O(LINK_OK_O), .TX_DISABLE_O(TX_DISABLE_O), .ANEG_RESTART_O(ANEG_RESTART_O),
    .AUTO_X_EN_O(AUTO_X_EN_O), .MDIX_FORCE_O(MDIX_FORCE_O),
    .PORT_LED_OUT_3_O(PORT_LED_OUT_3_O), .PORT_LED_OUT_2_O(PORT_LED_OUT_2_O),
    .PORT_LED_OUT_1_O(PORT_LED_OUT_1_O), .PORT_LED_OUT_0_O(PORT_LED_OUT_0_O));
